// [dv/mau_core_model.sv]
// Behavioural processor core that issues operations to the multiply-accumulate unit.
// Assumes the unit takes an operation on the edge after it is presented and answers one cycle later.
`timescale 1ns/1ps
`default_nettype none
module mau_core_model
    import mau_pkg::*;
(
    input wire logic clock,
    input wire logic [31:0] result,
    output logic op_valid,
    output mau_op_e op,
    output logic word_op,
    output logic [31:0] operand_x,
    output logic [31:0] operand_y,
    output logic [1:0] product_shift_factor,
    output logic [15:0] ext_word,
    output logic [31:0] addr_in,
    output logic [31:0] addr_update_in
);
    logic [7:0] saved_status;
    logic [31:0] saved_mask;
    initial
    begin
        op_valid = 1'b0;
        op = MAU_OP_NONE;
        word_op = 1'b0;
        operand_x = 32'h0;
        operand_y = 32'h0;
        product_shift_factor = 2'h0;
        ext_word = 16'h0;
        addr_in = 32'h0;
        addr_update_in = 32'h0;
    end
    task automatic issue(input mau_op_e o, input logic w, input logic [31:0] x, input logic [31:0] y,
                         input logic [1:0] sf, input logic [15:0] ew, input logic [31:0] a, input logic [31:0] b);
        @(posedge clock);
        op_valid <= 1'b1;
        op <= o;
        word_op <= w;
        operand_x <= x;
        operand_y <= y;
        product_shift_factor <= sf;
        ext_word <= ew;
        addr_in <= a;
        addr_update_in <= b;
    endtask
    // Operands are scrambled when idle so nothing can lean on stale values.
    task automatic idle();
        @(posedge clock);
        op_valid <= 1'b0;
        operand_x <= ~operand_x;
        operand_y <= ~operand_y;
    endtask
    // Status is loaded with zero after each store and restored last, so the saved words are bit exact.
    task automatic save_restore();
        issue(MAU_OP_STORE_STATUS, 1'b0, 32'h0, 32'h0, 2'h0, 16'h0, 32'h0, 32'h0);
        issue(MAU_OP_LOAD_STATUS, 1'b0, 32'h0, 32'h0, 2'h0, 16'h0, 32'h0, 32'h0);
        #1 saved_status = result[7:0];
        issue(MAU_OP_STORE_MASK, 1'b0, 32'h0, 32'h0, 2'h0, 16'h0, 32'h0, 32'h0);
        issue(MAU_OP_LOAD_STATUS, 1'b0, 32'h0, 32'h0, 2'h0, 16'h0, 32'h0, 32'h0);
        #1 saved_mask = result;
        issue(MAU_OP_LOAD_MASK, 1'b0, 32'h0, saved_mask, 2'h0, 16'h0, 32'h0, 32'h0);
        issue(MAU_OP_LOAD_STATUS, 1'b0, 32'h0, {24'h0, saved_status}, 2'h0, 16'h0, 32'h0, 32'h0);
    endtask
endmodule // mau_core_model
`default_nettype wire

// [dv/testbench.sv]
// Self-checking bench for the multiply-accumulate unit driven through a core model.
// Assumes results pulse result_valid or ccr_valid one cycle after the operation is taken.
`timescale 1ns/1ps
`default_nettype none
module testbench
    import mau_pkg::*;
;
    logic clock = 1'b0;
    logic resetn = 1'b0;
    logic op_valid, word_op, result_valid, ccr_valid;
    mau_op_e op_code;
    logic [31:0] operand_x, operand_y, addr_in, addr_update_in, result, addr_out, address_register, accumulator;
    logic [7:0] status_ctrl;
    logic [1:0] product_shift_factor;
    logic [15:0] ext_word;
    logic [4:0] condition_code_reg;
    logic [31:0] seed = 32'hA459C1C9;
    logic [31:0] x, y, e;
    logic [63:0] res_q[$];
    logic [9:0] ccr_q[$];
    logic [63:0] t;
    logic [9:0] c;
    int miscompares = 0;
    int num_checks = 0;
    always #50 clock = ~clock;
    mau_core_model u_mau_core_model (.clock(clock), .result(result), .op_valid(op_valid), .op(op_code),
        .word_op(word_op), .operand_x(operand_x), .operand_y(operand_y),
        .product_shift_factor(product_shift_factor), .ext_word(ext_word), .addr_in(addr_in),
        .addr_update_in(addr_update_in));
    mau_unit u_mau_unit (.clock(clock), .resetn(resetn), .op_valid(op_valid), .op(op_code), .word_op(word_op),
        .operand_x(operand_x), .operand_y(operand_y), .product_shift_factor(product_shift_factor),
        .ext_word(ext_word), .addr_in(addr_in), .addr_update_in(addr_update_in), .result(result),
        .result_valid(result_valid), .condition_code_reg(condition_code_reg), .ccr_valid(ccr_valid),
        .addr_out(addr_out), .address_register(address_register), .status_ctrl(status_ctrl),
        .accumulator(accumulator));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic push_res(input logic [31:0] v, input logic [31:0] m);
        res_q.push_back({v & m, m});
    endtask
    task automatic push_ccr(input logic [4:0] v, input logic [4:0] m);
        ccr_q.push_back({v & m, m});
    endtask
    task automatic op(input mau_op_e o, input logic w, input logic [31:0] a, input logic [31:0] b,
                      input logic [1:0] sf = MAU_SF_NONE);
        u_mau_core_model.issue(o, w, a, b, sf, 16'h0000, rnd(), rnd());
    endtask
    // An unexpected pulse pops a default whose zero mask can never match.
    always @(posedge clock)
    begin
        if (result_valid === 1'b1)
        begin
            t = (res_q.size() != 0) ? res_q.pop_front() : 64'h1_0000_0000;
            check(result & t[31:0], t[63:32]);
        end
        if (ccr_valid === 1'b1)
        begin
            c = (ccr_q.size() != 0) ? ccr_q.pop_front() : 10'h200;
            check({27'h0, condition_code_reg & c[4:0]}, {27'h0, c[9:5]});
        end
    end
    task automatic mac_chk(input logic [7:0] st, input mau_op_e o, input logic w, input logic [31:0] a,
                           input logic [31:0] b, input logic [1:0] sf, input logic [31:0] v);
        op(MAU_OP_LOAD_STATUS, 1'b0, 32'h0, {24'h0, st});
        op(MAU_OP_LOAD_ACC, 1'b0, 32'h0, 32'h0);
        op(o, w, a, b, sf);
        push_res(v, 32'hFFFFFFFF);
        op(MAU_OP_STORE_ACC, 1'b0, 32'h0, 32'h0);
        push_ccr({1'b0, v[31], (v == 32'h0), 2'b00}, 5'h1E);
        op(MAU_OP_STATUS_TO_CCR, 1'b0, 32'h0, 32'h0);
    endtask
    task automatic v_chk(input logic [7:0] st, input logic [31:0] acc, input logic w, input logic [31:0] a,
                         input logic [31:0] b);
        op(MAU_OP_LOAD_STATUS, 1'b0, 32'h0, {24'h0, st});
        op(MAU_OP_LOAD_ACC, 1'b0, 32'h0, acc);
        op(MAU_OP_MAC, w, a, b);
        push_ccr(5'h02, 5'h02);
        op(MAU_OP_STATUS_TO_CCR, 1'b0, 32'h0, 32'h0);
    endtask
    task automatic addr_chk(input logic en);
        logic [31:0] a;
        logic [31:0] b;
        logic [31:0] m;
        a = rnd();
        b = rnd();
        m = rnd();
        op(MAU_OP_LOAD_MASK, 1'b0, 32'h0, m);
        u_mau_core_model.issue(MAU_OP_MAC, 1'b1, 32'h0, 32'h0, MAU_SF_NONE, {10'h0, en, 5'h00}, a, b);
        u_mau_core_model.idle();
        #1;
        check(addr_out, en ? (a & {16'hFFFF, m[15:0]}) : a);
        check(address_register, en ? (b & {16'hFFFF, m[15:0]}) : b);
    endtask
    initial
    begin
        repeat (3000) @(posedge clock);
        miscompares++;
        tally_and_finish();
    end
    initial
    begin
        repeat (10) @(posedge clock);
        resetn <= 1'b1;
        for (int i = 0; i < 4; i++)
        begin
            y = rnd();
            op(MAU_OP_LOAD_MASK, 1'b0, 32'h0, y);
            push_res({16'hFFFF, y[15:0]}, 32'hFFFFFFFF);
            op(MAU_OP_STORE_MASK, 1'b0, 32'h0, 32'h0);
        end
        for (int i = 0; i < 6; i++)
        begin
            x = rnd();
            y = rnd();
            op(MAU_OP_LOAD_STATUS, 1'b0, 32'h0, {24'h0, (8'(i % 3) << 5)});
            e = $signed(x[15:0]) * $signed(y[15:0]);
            push_res(e, 32'hFFFFFFFF);
            op(MAU_OP_SIGNED_MUL, 1'b1, x, y);
            e = x[15:0] * y[15:0];
            push_res(e, 32'hFFFFFFFF);
            op(MAU_OP_UNSIGNED_MUL, 1'b1, x, y);
        end
        op(MAU_OP_LOAD_ACC, 1'b0, 32'h0, 32'h80000000);
        push_res(32'h0, 32'hFFFFFFFF);
        op(MAU_OP_SIGNED_MUL, 1'b1, 32'h0, 32'h0);
        push_ccr(5'h08, 5'h1C);
        op(MAU_OP_STATUS_TO_CCR, 1'b0, 32'h0, 32'h0);
        mac_chk(8'h00, MAU_OP_MAC, 1'b1, 32'hFFFD, 32'h5, MAU_SF_NONE, 32'hFFFFFFF1);
        mac_chk(8'h00, MAU_OP_MAC, 1'b1, 32'hFFFD, 32'h5, 2'h2, 32'hFFFFFFF1);
        mac_chk(8'h00, MAU_OP_MAC, 1'b1, 32'hFFFD, 32'h5, MAU_SF_LEFT, 32'hFFFFFFE2);
        mac_chk(8'h00, MAU_OP_MAC, 1'b1, 32'hFFFD, 32'h5, MAU_SF_RIGHT, 32'hFFFFFFF8);
        mac_chk(8'h00, MAU_OP_MAC, 1'b1, 32'h0, 32'h5, MAU_SF_RIGHT, 32'h0);
        mac_chk(8'h00, MAU_OP_MAC, 1'b0, 32'hFFFFFFF9, 32'h3, MAU_SF_RIGHT, 32'hFFFFFFF5);
        mac_chk(8'h00, MAU_OP_MULTIPLY_SUBTRACT_ACCUMULATE, 1'b1, 32'hFFFD, 32'h5, MAU_SF_NONE, 32'hF);
        mac_chk(8'h00, MAU_OP_MULTIPLY_SUBTRACT_ACCUMULATE, 1'b1, 32'hFFFD, 32'h5, MAU_SF_LEFT, 32'h1E);
        mac_chk(8'h40, MAU_OP_MAC, 1'b1, 32'hFFFF, 32'hFFFF, MAU_SF_RIGHT, 32'h7FFF0000);
        mac_chk(8'h40, MAU_OP_MAC, 1'b1, 32'hFF, 32'h101, MAU_SF_LEFT, 32'h1FFFE);
        mac_chk(8'h20, MAU_OP_MAC, 1'b1, 32'h4000, 32'h2000, MAU_SF_NONE, 32'h10000000);
        mac_chk(8'h20, MAU_OP_MAC, 1'b1, 32'h4000, 32'h2000, MAU_SF_LEFT, 32'h10000000);
        mac_chk(8'h20, MAU_OP_MAC, 1'b1, 32'h4000, 32'h2000, MAU_SF_RIGHT, 32'h10000000);
        mac_chk(8'h20, MAU_OP_MAC, 1'b1, 32'h8000, 32'h4000, MAU_SF_NONE, 32'hC0000000);
        v_chk(8'h00, 32'h7FFFFFFF, 1'b1, 32'h1, 32'h1);
        v_chk(8'h40, 32'hFFFFFFFF, 1'b1, 32'h1, 32'h1);
        v_chk(8'h00, 32'h0, 1'b0, 32'h10000, 32'h10000);
        // An overflowed signed longword product must take a zero fill on a right shift.
        op(MAU_OP_LOAD_ACC, 1'b0, 32'h0, 32'h0);
        op(MAU_OP_MAC, 1'b0, 32'h40000000, 32'h3, MAU_SF_RIGHT);
        push_res(32'h60000000, 32'hFFFFFFFF);
        op(MAU_OP_STORE_ACC, 1'b0, 32'h0, 32'h0);
        addr_chk(1'b1);
        addr_chk(1'b0);
        y = rnd();
        op(MAU_OP_LOAD_MASK, 1'b0, 32'h0, y);
        op(MAU_OP_LOAD_ACC, 1'b0, 32'h0, y);
        op(MAU_OP_LOAD_STATUS, 1'b0, 32'h0, 32'h50);
        push_res(32'h50, 32'hFF);
        push_res({16'hFFFF, y[15:0]}, 32'hFFFFFFFF);
        u_mau_core_model.save_restore();
        push_res(32'h50, 32'hFF);
        op(MAU_OP_STORE_STATUS, 1'b0, 32'h0, 32'h0);
        push_res({16'hFFFF, y[15:0]}, 32'hFFFFFFFF);
        op(MAU_OP_STORE_MASK, 1'b0, 32'h0, 32'h0);
        u_mau_core_model.idle();
        repeat (4) @(posedge clock);
        check(32'(res_q.size() + ccr_q.size()), 32'h0);
        check({24'h0, status_ctrl}, 32'h50);
        check(accumulator, y);
        tally_and_finish();
    end
endmodule // testbench
`default_nettype wire

// [rtl/mau_addr_mask.sv]
// Operand address masking for multiply-and-move operations.
// Assumes the core computes the normal and updated addresses before masking.
`timescale 1ns/1ps
`default_nettype none
module mau_addr_mask
    import mau_pkg::*;
(
    input wire logic [31:0] addr_in,
    input wire logic [31:0] addr_update_in,
    input wire logic [15:0] mask,
    input wire logic [15:0] ext_word,
    output logic [31:0] addr_out,
    output logic [31:0] addr_update_out
);
    logic [31:0] full_mask;
    logic enable;

    always_comb
    begin
        enable = ext_word[MAU_EXT_MASK_BIT];
        full_mask = {MAU_MASK_UPPER, mask};
        addr_out = enable ? (addr_in & full_mask) : addr_in;
        // The updated pointer is masked too, so a circular queue wraps in place.
        addr_update_out = enable ? (addr_update_in & full_mask) : addr_update_in;
    end
endmodule // mau_addr_mask
`default_nettype wire

// [rtl/mau_pkg.sv]
// Shared constants and types of the multiply-accumulate unit.
// Assumes a single core clock domain; the core issues one operation at a time.
package mau_pkg;
    // Operation codes issued by the core.
    typedef enum logic [3:0] {
        MAU_OP_NONE,
        MAU_OP_SIGNED_MUL,
        MAU_OP_UNSIGNED_MUL,
        MAU_OP_MAC,
        MAU_OP_MULTIPLY_SUBTRACT_ACCUMULATE,
        MAU_OP_LOAD_ACC,
        MAU_OP_LOAD_STATUS,
        MAU_OP_STORE_STATUS,
        MAU_OP_STATUS_TO_CCR,
        MAU_OP_LOAD_MASK,
        MAU_OP_STORE_MASK,
        MAU_OP_STORE_ACC
    } mau_op_e;

    // Product shift factor encodings.
    localparam logic [1:0] MAU_SF_NONE = 2'h0;
    localparam logic [1:0] MAU_SF_LEFT = 2'h1;
    localparam logic [1:0] MAU_SF_RIGHT = 2'h3;

    // Status/control field positions.
    localparam int MAU_SC_OMC = 7;
    localparam int MAU_SC_SU = 6;
    localparam int MAU_SC_FI = 5;
    localparam int MAU_SC_RT = 4;
    localparam int MAU_SC_N = 3;
    localparam int MAU_SC_Z = 2;
    localparam int MAU_SC_V = 1;
    localparam int MAU_SC_EV = 0;
    localparam logic [7:0] MAU_SC_WMASK = 8'hFF;

    // Masking enable bit in the extension word.
    localparam int MAU_EXT_MASK_BIT = 5;
    localparam logic [15:0] MAU_MASK_UPPER = 16'hFFFF;

    // Reset values.
    localparam logic [7:0] MAU_SC_RESET = 8'h00;
    localparam logic [15:0] MAU_MASK_RESET = 16'h0000;
    localparam logic [31:0] MAU_ACC_RESET = 32'h0000_0000;
endpackage : mau_pkg

// [rtl/mau_prod_shift.sv]
// One-bit product shifter used ahead of the accumulator adder.
// Assumes the product and its overflow flag arrive from the multiplier in the same cycle.
`timescale 1ns/1ps
`default_nettype none
module mau_prod_shift
    import mau_pkg::*;
(
    input wire logic [31:0] prod,
    input wire logic [1:0] shift_factor,
    input wire logic fractional,
    input wire logic unsigned_mode,
    input wire logic word_op,
    input wire logic prod_ovf,
    output logic [31:0] shifted
);
    logic fill;

    always_comb
    begin
        fill = 1'b0;
        if (unsigned_mode)
            fill = 1'b0;
        else if (word_op)
            fill = (prod != 32'h0000_0000) ? prod[31] : 1'b0;
        else
            fill = (prod_ovf || prod == 32'h0000_0000) ? 1'b0 : prod[31];
        shifted = prod;
        if (!fractional)
        begin
            if (shift_factor == MAU_SF_LEFT)
                shifted = {prod[30:0], 1'b0};
            else if (shift_factor == MAU_SF_RIGHT)
                shifted = {fill, prod[31:1]};
        end
    end
endmodule // mau_prod_shift
`default_nettype wire

// [rtl/mau_unit.sv]
// Multiply-accumulate datapath with status/control and address mask registers.
// Assumes the core presents one operation per op_valid pulse and reads results a cycle later.
// Contract
// - Multiplies treat operands as integers always
// - Fractional mode ignores product shift factor
// - Mask write keeps low sixteen bits
// - Mask read returns upper half ones
// - Masked address ANDs with ones-extended mask
// - Extension bit five enables masking
// - Select bits choose one of three formats
// - Sign-only pattern is minus one fractional
// - Negative and zero follow final combine result
// - Overflow on product or accumulate overflow
// - Optional one-bit shift precedes accumulation
// - Unsigned right shift inserts zero
// - Signed word right shift inserts sign
// - Signed long right shift zero on overflow
// - Left shift inserts zero lsb
// - Signed and unsigned multiplies keep signedness
// - Moves load, store, copy to condition codes
// - Negative updated only by accumulate and load
`timescale 1ns/1ps
`default_nettype none
module mau_unit
    import mau_pkg::*;
(
    input wire logic clock,
    input wire logic resetn,
    input wire logic op_valid,
    input wire mau_op_e op,
    input wire logic word_op,
    input wire logic [31:0] operand_x,
    input wire logic [31:0] operand_y,
    input wire logic [1:0] product_shift_factor,
    input wire logic [15:0] ext_word,
    input wire logic [31:0] addr_in,
    input wire logic [31:0] addr_update_in,
    output logic [31:0] result,
    output logic result_valid,
    output logic [4:0] condition_code_reg,
    output logic ccr_valid,
    output logic [31:0] addr_out,
    output logic [31:0] address_register,
    output logic [7:0] status_ctrl,
    output logic [31:0] accumulator
);
    logic [7:0] sc_reg, sc_next;
    logic [15:0] mask_reg, mask_next;
    logic [31:0] acc_reg, acc_next;
    logic [31:0] result_reg, result_next;
    logic result_valid_reg, result_valid_next;
    logic [4:0] ccr_reg, ccr_next;
    logic ccr_valid_reg, ccr_valid_next;
    logic [31:0] addr_reg, addr_next;
    logic [31:0] upd_reg, upd_next;

    logic fractional, unsigned_mode;
    logic [31:0] ox, oy;
    logic signed [63:0] sprod;
    logic [63:0] uprod;
    logic [31:0] prod32;
    logic prod_ovf;
    logic [31:0] shifted;
    logic [32:0] sum;
    logic acc_ovf;
    logic [31:0] masked_addr, masked_upd;

    assign fractional = sc_reg[MAU_SC_FI];
    assign unsigned_mode = sc_reg[MAU_SC_SU] && !sc_reg[MAU_SC_FI];

    // Word operands use the low half; plain multiplies always take the integer extension of their own kind.
    always_comb
    begin
        ox = operand_x;
        oy = operand_y;
        if (word_op)
        begin
            if (fractional && op != MAU_OP_SIGNED_MUL && op != MAU_OP_UNSIGNED_MUL)
            begin
                // Fractional words sit in the upper half so 0x8000 scales to minus one.
                ox = {operand_x[15:0], 16'h0000};
                oy = {operand_y[15:0], 16'h0000};
            end
            else if (op == MAU_OP_UNSIGNED_MUL || (unsigned_mode && op != MAU_OP_SIGNED_MUL))
            begin
                ox = {16'h0000, operand_x[15:0]};
                oy = {16'h0000, operand_y[15:0]};
            end
            else
            begin
                ox = {{16{operand_x[15]}}, operand_x[15:0]};
                oy = {{16{operand_y[15]}}, operand_y[15:0]};
            end
        end
    end

    assign sprod = $signed(ox) * $signed(oy);
    assign uprod = ox * oy;

    // Product selection and overflow for the accumulate path.
    always_comb
    begin
        prod32 = sprod[31:0];
        prod_ovf = 1'b0;
        if (fractional)
        begin
            // Q31 times Q31 gives Q62; drop the redundant sign to return to Q31.
            prod32 = sprod[62:31];
            prod_ovf = (ox == 32'h8000_0000) && (oy == 32'h8000_0000);
        end
        else if (unsigned_mode)
        begin
            prod32 = uprod[31:0];
            prod_ovf = uprod[63:32] != 32'h0000_0000;
        end
        else
        begin
            prod32 = sprod[31:0];
            prod_ovf = sprod[63:32] != {32{sprod[31]}};
        end
    end

    mau_prod_shift u_shift (
        .prod(prod32),
        .shift_factor(product_shift_factor),
        .fractional(fractional),
        .unsigned_mode(unsigned_mode),
        .word_op(word_op),
        .prod_ovf(prod_ovf),
        .shifted(shifted)
    );

    // Combine the shifted product with the accumulator.
    always_comb
    begin
        sum = 33'h0_0000_0000;
        acc_ovf = 1'b0;
        if (op == MAU_OP_MULTIPLY_SUBTRACT_ACCUMULATE)
            sum = {1'b0, acc_reg} - {1'b0, shifted};
        else
            sum = {1'b0, acc_reg} + {1'b0, shifted};
        if (unsigned_mode)
            acc_ovf = sum[32];
        else if (op == MAU_OP_MULTIPLY_SUBTRACT_ACCUMULATE)
            acc_ovf = (acc_reg[31] != shifted[31]) && (sum[31] != acc_reg[31]);
        else
            acc_ovf = (acc_reg[31] == shifted[31]) && (sum[31] != acc_reg[31]);
    end

    mau_addr_mask u_mask (
        .addr_in(addr_in),
        .addr_update_in(addr_update_in),
        .mask(mask_reg),
        .ext_word(ext_word),
        .addr_out(masked_addr),
        .addr_update_out(masked_upd)
    );

    // Operation sequencing.
    always_comb
    begin
        sc_next = sc_reg;
        mask_next = mask_reg;
        acc_next = acc_reg;
        result_next = result_reg;
        result_valid_next = 1'b0;
        ccr_next = ccr_reg;
        ccr_valid_next = 1'b0;
        addr_next = addr_reg;
        upd_next = upd_reg;
        if (op_valid)
        begin
            case (op)
                MAU_OP_SIGNED_MUL:
                begin
                    // Integer product always, fractional mode notwithstanding; flags untouched.
                    result_next = sprod[31:0];
                    result_valid_next = 1'b1;
                end
                MAU_OP_UNSIGNED_MUL:
                begin
                    result_next = uprod[31:0];
                    result_valid_next = 1'b1;
                end
                MAU_OP_MAC, MAU_OP_MULTIPLY_SUBTRACT_ACCUMULATE:
                begin
                    acc_next = sum[31:0];
                    sc_next[MAU_SC_N] = sum[31];
                    sc_next[MAU_SC_Z] = sum[31:0] == 32'h0000_0000;
                    sc_next[MAU_SC_V] = prod_ovf || acc_ovf;
                    addr_next = masked_addr;
                    upd_next = masked_upd;
                end
                MAU_OP_LOAD_ACC:
                begin
                    acc_next = operand_y;
                    sc_next[MAU_SC_N] = operand_y[31];
                    sc_next[MAU_SC_Z] = operand_y == 32'h0000_0000;
                    sc_next[MAU_SC_V] = 1'b0;
                end
                MAU_OP_LOAD_STATUS: sc_next = operand_y[7:0] & MAU_SC_WMASK;
                MAU_OP_STORE_STATUS:
                begin
                    result_next = {24'h000000, sc_reg};
                    result_valid_next = 1'b1;
                end
                MAU_OP_STATUS_TO_CCR:
                begin
                    ccr_next = {1'b0, sc_reg[3:0]};
                    ccr_valid_next = 1'b1;
                end
                MAU_OP_LOAD_MASK: mask_next = operand_y[15:0];
                MAU_OP_STORE_MASK:
                begin
                    result_next = {MAU_MASK_UPPER, mask_reg};
                    result_valid_next = 1'b1;
                end
                MAU_OP_STORE_ACC:
                begin
                    result_next = acc_reg;
                    result_valid_next = 1'b1;
                end
                default:
                begin
                    result_valid_next = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            sc_reg <= MAU_SC_RESET;
            mask_reg <= MAU_MASK_RESET;
            acc_reg <= MAU_ACC_RESET;
            result_reg <= 32'h0000_0000;
            result_valid_reg <= 1'b0;
            ccr_reg <= 5'h00;
            ccr_valid_reg <= 1'b0;
            addr_reg <= 32'h0000_0000;
            upd_reg <= 32'h0000_0000;
        end
        else
        begin
            sc_reg <= sc_next;
            mask_reg <= mask_next;
            acc_reg <= acc_next;
            result_reg <= result_next;
            result_valid_reg <= result_valid_next;
            ccr_reg <= ccr_next;
            ccr_valid_reg <= ccr_valid_next;
            addr_reg <= addr_next;
            upd_reg <= upd_next;
        end
    end

    assign result = result_reg;
    assign result_valid = result_valid_reg;
    assign condition_code_reg = ccr_reg;
    assign ccr_valid = ccr_valid_reg;
    assign addr_out = addr_reg;
    assign address_register = upd_reg;
    assign status_ctrl = sc_reg;
    assign accumulator = acc_reg;

    property p_mask_read;
        @(posedge clock) disable iff (!resetn)
        op_valid && op == MAU_OP_STORE_MASK |=> result[31:16] == 16'hFFFF && result_valid;
    endproperty
    a_mask_read: assert property (p_mask_read) else $error("mask read upper half not ones");

    property p_mask_write;
        @(posedge clock) disable iff (!resetn)
        op_valid && op == MAU_OP_LOAD_MASK ##1 op_valid && op == MAU_OP_STORE_MASK
        |=> result[15:0] == $past(operand_y[15:0], 2);
    endproperty
    a_mask_write: assert property (p_mask_write) else $error("mask did not keep low half");

    property p_mul_flags;
        @(posedge clock) disable iff (!resetn)
        op_valid && (op == MAU_OP_SIGNED_MUL || op == MAU_OP_UNSIGNED_MUL) |=> $stable(status_ctrl[3:1]);
    endproperty
    a_mul_flags: assert property (p_mul_flags) else $error("multiply changed flags");

    property p_zero_flag;
        @(posedge clock) disable iff (!resetn)
        op_valid && (op == MAU_OP_MAC || op == MAU_OP_MULTIPLY_SUBTRACT_ACCUMULATE)
        |=> status_ctrl[MAU_SC_Z] == (accumulator == 32'h0000_0000) && status_ctrl[MAU_SC_N] == accumulator[31];
    endproperty
    a_zero_flag: assert property (p_zero_flag) else $error("flags do not follow accumulator");

    property p_mask_addr;
        @(posedge clock) disable iff (!resetn)
        op_valid && op == MAU_OP_MAC && ext_word[MAU_EXT_MASK_BIT]
        |=> addr_out == ($past(addr_in) & {16'hFFFF, $past(mask_reg)});
    endproperty
    a_mask_addr: assert property (p_mask_addr) else $error("masked address wrong");

    property p_nomask_addr;
        @(posedge clock) disable iff (!resetn)
        op_valid && op == MAU_OP_MAC && !ext_word[MAU_EXT_MASK_BIT] |=> addr_out == $past(addr_in);
    endproperty
    a_nomask_addr: assert property (p_nomask_addr) else $error("address masked while disabled");

    property p_upd_addr;
        @(posedge clock) disable iff (!resetn)
        op_valid && op == MAU_OP_MAC && ext_word[MAU_EXT_MASK_BIT]
        |=> address_register[31:16] == $past(addr_update_in[31:16]);
    endproperty
    a_upd_addr: assert property (p_upd_addr) else $error("updated pointer upper half changed");

    property p_frac_noshift;
        @(posedge clock) disable iff (!resetn)
        fractional |-> shifted == prod32;
    endproperty
    a_frac_noshift: assert property (p_frac_noshift) else $error("shift applied in fractional mode");

    property p_left_lsb;
        @(posedge clock) disable iff (!resetn)
        !fractional && product_shift_factor == MAU_SF_LEFT |-> shifted == {prod32[30:0], 1'b0};
    endproperty
    a_left_lsb: assert property (p_left_lsb) else $error("left shift lsb not zero");

    property p_ccr_copy;
        @(posedge clock) disable iff (!resetn)
        op_valid && op == MAU_OP_STATUS_TO_CCR |=> ccr_valid && condition_code_reg[3:0] == status_ctrl[3:0];
    endproperty
    a_ccr_copy: assert property (p_ccr_copy) else $error("ccr copy wrong");

    c_mac: cover property (@(posedge clock) disable iff (!resetn) op_valid && op == MAU_OP_MAC);
    c_multiply_subtract_accumulate_ovf: cover property (@(posedge clock) disable iff (!resetn) op_valid && op == MAU_OP_MULTIPLY_SUBTRACT_ACCUMULATE && acc_ovf);
    c_masked: cover property (@(posedge clock) disable iff (!resetn) op_valid && ext_word[MAU_EXT_MASK_BIT]);
    c_frac: cover property (@(posedge clock) disable iff (!resetn) op_valid && op == MAU_OP_MAC && fractional);
endmodule // mau_unit
`default_nettype wire
